// ---- pkg/umu_params.svh ----
// Purpose : constants for the unsigned multiplier unit
// Assumes : included by bare name from the package and design files
// Notes   : widths are fixed, nothing here is tunable per instance
`ifndef UMU_PARAMS_SVH
`define UMU_PARAMS_SVH

// ----------------------------------------------------------------------
// mode control encodings and reset values
// ----------------------------------------------------------------------
`define UMU_MODE_W     8
`define UMU_MODE_MUL   8'h00
`define UMU_MODE_RST   8'h00
`define UMU_OPND_W     16
`define UMU_OPND_RST   16'h0000
`define UMU_PROD_W     32
`define UMU_PROD_RST   32'h0000_0000

// ----------------------------------------------------------------------
// field positions of the product
// ----------------------------------------------------------------------
`define UMU_PROD_LO_MSB 15
`define UMU_PROD_LO_LSB 0
`define UMU_PROD_HI_MSB 31
`define UMU_PROD_HI_LSB 16

// ----------------------------------------------------------------------
// timing: operation clocks from start to product
// ----------------------------------------------------------------------
`define UMU_OP_CLKS    1

`endif

// ---- pkg/umu_pkg.sv ----
// Purpose : shared types of the unsigned multiplier unit
// Assumes : umu_params.svh on the include path
// Notes   : state codes are one-hot and written out
`include "umu_params.svh"

package umu_pkg;

   // ----------------------------------------------------------------------
   // data types
   // ----------------------------------------------------------------------
   typedef logic [`UMU_MODE_W-1:0] umu_mode_t;
   typedef logic [`UMU_OPND_W-1:0] umu_opnd_t;
   typedef logic [`UMU_PROD_W-1:0] umu_prod_t;

   // ----------------------------------------------------------------------
   // sequencer states
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      UMU_ST_IDLE = 2'b01,
      UMU_ST_CALC = 2'b10
   } umu_state_t;

   // true when the mode control selects unsigned multiply
   function automatic logic umu_is_mul(input umu_mode_t mode);
      return mode == `UMU_MODE_MUL;
   endfunction

endpackage

// ---- pkg/umu_mul_if.sv ----
// Purpose : carries operands to the array multiplier and its product back
// Assumes : both ends sit in the same clock domain
// Notes   : purely combinational path, the caller registers the product
interface umu_mul_if;
   import umu_pkg::*;

   umu_opnd_t mcand;
   umu_opnd_t mplier;
   umu_prod_t product;

   // ----------------------------------------------------------------------
   // modports
   // ----------------------------------------------------------------------
   modport ctrl (output mcand, output mplier, input product);
   modport core (input mcand, input mplier, output product);
endinterface

// ---- rtl/umu_mult.sv ----
// Purpose : 16x16 unsigned array multiply
// Assumes : inputs held stable for the one operation clock
// Notes   : result is combinational, registered by the sequencer
module umu_mult
   import umu_pkg::*;
(
   // operands in, product out
   umu_mul_if.core mul
);

   // full-width product, no truncation
   always_comb begin
      mul.product = umu_prod_t'(mul.mcand) * umu_prod_t'(mul.mplier);
   end

endmodule

// ---- rtl/umu_top.sv ----
// Purpose : unsigned multiply part of a multiply/divide unit
// Assumes : all inputs synchronous to clk, ce gates every state change except reset
// Notes   : only the multiply mode is implemented; other modes just store
`include "umu_params.svh"

module umu_top
   import umu_pkg::*;
(
   // clock, reset, enable
   input  wire logic      clk,
   input  wire logic      reset,
   input  wire logic      ce,
   // register writes
   input  wire logic      mode_wr,
   input  wire umu_mode_t mode_wdata,
   input  wire logic      opl_wr,
   input  wire umu_opnd_t opl_wdata,
   input  wire logic      oph_wr,
   input  wire umu_opnd_t oph_wdata,
   // product read port
   input  wire logic      rd_en,
   input  wire logic      rd_sel_high,
   output umu_opnd_t      rd_data,
   // register contents
   output umu_mode_t      muldiv_mode_control,
   output umu_opnd_t      operand_low_reg,
   output umu_opnd_t      operand_high_reg,
   output umu_opnd_t      product_low_reg,
   output umu_opnd_t      product_high_reg,
   // status
   output logic           busy,
   output logic           done
);

   // ----------------------------------------------------------------------
   // state
   // ----------------------------------------------------------------------
   umu_state_t state_r, state_nxt;
   umu_mode_t  mode_r, mode_nxt;
   umu_opnd_t  opl_r, opl_nxt;
   umu_opnd_t  oph_r, oph_nxt;
   logic       lo_ok_r, lo_ok_nxt;
   logic       hi_ok_r, hi_ok_nxt;
   umu_opnd_t  a_lat_r, a_lat_nxt;
   umu_opnd_t  b_lat_r, b_lat_nxt;
   umu_prod_t  prod_r, prod_nxt;
   umu_opnd_t  rd_r, rd_nxt;
   logic       done_r, done_nxt;
   logic       go;

   umu_mul_if mul ();

   // ----------------------------------------------------------------------
   // multiplier core
   // ----------------------------------------------------------------------
   umu_mult u_mult (
      .mul (mul.core)
   );

   // latched copies drive the core so operand writes during the
   // operation clock cannot corrupt the product in flight
   assign mul.mcand  = a_lat_r;
   assign mul.mplier = b_lat_r;

   // start once both operands are in and multiply mode is selected
   assign go = (state_r == UMU_ST_IDLE) && lo_ok_r && hi_ok_r &&
               umu_is_mul(mode_r);

   // ----------------------------------------------------------------------
   // next-state logic
   // ----------------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      mode_nxt  = mode_r;
      opl_nxt   = opl_r;
      oph_nxt   = oph_r;
      lo_ok_nxt = lo_ok_r;
      hi_ok_nxt = hi_ok_r;
      a_lat_nxt = a_lat_r;
      b_lat_nxt = b_lat_r;
      prod_nxt  = prod_r;
      rd_nxt    = rd_r;
      done_nxt  = 1'b0;

      // a mode change asks for a fresh operand pair
      if (mode_wr) begin
         mode_nxt  = mode_wdata;
         lo_ok_nxt = 1'b0;
         hi_ok_nxt = 1'b0;
      end

      unique case (state_r)
         UMU_ST_IDLE: begin
            if (go) begin
               a_lat_nxt = opl_r;
               b_lat_nxt = oph_r;
               hi_ok_nxt = 1'b0;
               state_nxt = UMU_ST_CALC;
            end
         end
         UMU_ST_CALC: begin
            prod_nxt  = mul.product;
            done_nxt  = 1'b1;
            state_nxt = UMU_ST_IDLE;
         end
      endcase

      // writes come after the start so a set in the start cycle wins
      if (opl_wr && !mode_wr) begin
         opl_nxt   = opl_wdata;
         lo_ok_nxt = 1'b1;
      end else if (opl_wr) begin
         opl_nxt = opl_wdata;
      end
      if (oph_wr && !mode_wr) begin
         oph_nxt   = oph_wdata;
         hi_ok_nxt = 1'b1;
      end else if (oph_wr) begin
         oph_nxt = oph_wdata;
      end

      // reads only copy the old product, the halves are left alone
      if (rd_en) begin
         rd_nxt = rd_sel_high ?
                  prod_r[`UMU_PROD_HI_MSB:`UMU_PROD_HI_LSB] :
                  prod_r[`UMU_PROD_LO_MSB:`UMU_PROD_LO_LSB];
      end
   end

   // ----------------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= UMU_ST_IDLE;
         mode_r  <= `UMU_MODE_RST;
         opl_r   <= `UMU_OPND_RST;
         oph_r   <= `UMU_OPND_RST;
         lo_ok_r <= 1'b0;
         hi_ok_r <= 1'b0;
         a_lat_r <= `UMU_OPND_RST;
         b_lat_r <= `UMU_OPND_RST;
         prod_r  <= `UMU_PROD_RST;
         rd_r    <= `UMU_OPND_RST;
         done_r  <= 1'b0;
      end else if (ce) begin
         state_r <= state_nxt;
         mode_r  <= mode_nxt;
         opl_r   <= opl_nxt;
         oph_r   <= oph_nxt;
         lo_ok_r <= lo_ok_nxt;
         hi_ok_r <= hi_ok_nxt;
         a_lat_r <= a_lat_nxt;
         b_lat_r <= b_lat_nxt;
         prod_r  <= prod_nxt;
         rd_r    <= rd_nxt;
         done_r  <= done_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   assign muldiv_mode_control = mode_r;
   assign operand_low_reg     = opl_r;
   assign operand_high_reg    = oph_r;
   assign product_low_reg     = prod_r[`UMU_PROD_LO_MSB:`UMU_PROD_LO_LSB];
   assign product_high_reg    = prod_r[`UMU_PROD_HI_MSB:`UMU_PROD_HI_LSB];
   assign rd_data             = rd_r;
   // busy tells the caller the product is not yet valid
   assign busy                = (state_r == UMU_ST_CALC) || go;
   assign done                = done_r;

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // no start unless the mode is multiply
   property p_mode_gate;
      (ce && state_r == UMU_ST_IDLE && !umu_is_mul(mode_r))
         |=> state_r == UMU_ST_IDLE;
   endproperty
   a_mode_gate: assert property (p_mode_gate)
      else $error("multiply started outside multiply mode");

   // operands land in the core in the documented roles
   property p_operand_roles;
      (ce && go) |=> (a_lat_r == $past(opl_r)) && (b_lat_r == $past(oph_r));
   endproperty
   a_operand_roles: assert property (p_operand_roles)
      else $error("operands latched in the wrong roles");

   // both flags set in multiply mode starts the operation
   property p_auto_start;
      (ce && state_r == UMU_ST_IDLE && lo_ok_r && hi_ok_r &&
       umu_is_mul(mode_r)) |=> state_r == UMU_ST_CALC;
   endproperty
   a_auto_start: assert property (p_auto_start)
      else $error("operation did not start with both operands in");

   // one operation clock, then back to idle with done
   property p_one_clock;
      (ce && state_r == UMU_ST_CALC) |=> state_r == UMU_ST_IDLE && done;
   endproperty
   a_one_clock: assert property (p_one_clock)
      else $error("operation took other than one clock");

   // low half of the product
   property p_prod_low;
      (ce && state_r == UMU_ST_CALC) |=>
         product_low_reg == $past(umu_opnd_t'(a_lat_r * b_lat_r));
   endproperty
   a_prod_low: assert property (p_prod_low)
      else $error("low product half wrong");

   // high half of the product
   property p_prod_high;
      (ce && state_r == UMU_ST_CALC) |=>
         {product_high_reg, product_low_reg} ==
         $past(umu_prod_t'(a_lat_r) * umu_prod_t'(b_lat_r));
   endproperty
   a_prod_high: assert property (p_prod_high)
      else $error("high product half wrong");

   // a read returns the half asked for and moves nothing
   property p_read_clean;
      (ce && rd_en && state_r == UMU_ST_IDLE) |=>
         rd_data == ($past(rd_sel_high) ? product_high_reg
                                         : product_low_reg);
   endproperty
   a_read_clean: assert property (p_read_clean)
      else $error("read disturbed or misrouted product");

   // mode and low operand survive an operation; a mode write in the
   // start cycle may already have dropped the low flag, so need it set
   property p_keep_setup;
      (ce && state_r == UMU_ST_CALC && lo_ok_r && !mode_wr && !opl_wr) |=>
         lo_ok_r && $stable(mode_r) && $stable(opl_r);
   endproperty
   a_keep_setup: assert property (p_keep_setup)
      else $error("setup lost between operations");

   // product moves only at the end of an operation
   property p_hold_product;
      !(ce && state_r == UMU_ST_CALC) |=> $stable(prod_r);
   endproperty
   a_hold_product: assert property (p_hold_product)
      else $error("product changed without an operation");

   // main scenarios
   c_full_op:   cover property (ce && go ##1 ce && state_r == UMU_ST_CALC);
   c_mplr_only: cover property (ce && go && !opl_wr ##2 done ##[1:20]
                                ce && oph_wr && !opl_wr && !mode_wr);
   c_max_prod:  cover property (done && prod_r == 32'hfffe_0001);

endmodule

// ---- bench/umu_tb.sv ----
// Purpose : self-checking bench for the unsigned multiplier unit
// Assumes : one clock, synchronous active-high reset, ce held high except in the freeze scenario
// Notes   : stimulus on rising edges by non-blocking assignment
module testbench
   import umu_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // -------------------------------------------------------------------
   // clock, reset and design signals
   // -------------------------------------------------------------------
   logic      clk;
   logic      reset;
   logic      ce;
   logic      mode_wr;
   umu_mode_t mode_wdata;
   logic      opl_wr;
   umu_opnd_t opl_wdata;
   logic      oph_wr;
   umu_opnd_t oph_wdata;
   logic      rd_en;
   logic      rd_sel_high;
   umu_opnd_t rd_data;
   umu_mode_t muldiv_mode_control;
   umu_opnd_t operand_low_reg;
   umu_opnd_t operand_high_reg;
   umu_opnd_t product_low_reg;
   umu_opnd_t product_high_reg;
   logic      busy;
   logic      done;
   int        mismatches;
   int        comparisons;
   int        cycles;

   umu_top umu_top_inst (
      .clk(clk), .reset(reset), .ce(ce),
      .mode_wr(mode_wr), .mode_wdata(mode_wdata),
      .opl_wr(opl_wr), .opl_wdata(opl_wdata),
      .oph_wr(oph_wr), .oph_wdata(oph_wdata),
      .rd_en(rd_en), .rd_sel_high(rd_sel_high), .rd_data(rd_data),
      .muldiv_mode_control(muldiv_mode_control),
      .operand_low_reg(operand_low_reg),
      .operand_high_reg(operand_high_reg),
      .product_low_reg(product_low_reg),
      .product_high_reg(product_high_reg),
      .busy(busy), .done(done)
   );

   // 50 ns period; the 2000-cycle ceiling is far above the roughly 60 cycles used
   always #25 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles >= 2000) begin
         mismatches++;
         complete_run();
      end
   end

   // -------------------------------------------------------------------
   // shared tasks
   // -------------------------------------------------------------------
   task automatic chk(input string what, input logic [31:0] exp,
                      input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one write cycle, strobes dropped at the sampling edge
   task automatic wr(input logic dm, input umu_mode_t m, input logic dl,
                     input umu_opnd_t l, input logic dh,
                     input umu_opnd_t h);
      @(posedge clk);
      mode_wr    <= dm;
      mode_wdata <= m;
      opl_wr     <= dl;
      opl_wdata  <= l;
      oph_wr     <= dh;
      oph_wdata  <= h;
      @(posedge clk);
      mode_wr <= 1'b0;
      opl_wr  <= 1'b0;
      oph_wr  <= 1'b0;
   endtask

   // follows the go cycle, calc cycle and product cycle after a write
   task automatic run_op(input umu_opnd_t a, input umu_opnd_t b,
                         input umu_prod_t old);
      umu_prod_t exp;
      exp = umu_prod_t'(a) * umu_prod_t'(b);
      #1;
      chk("busy go", 32'h1, busy);
      chk("done go", 32'h0, done);
      @(posedge clk);
      #1;
      chk("prod calc", old, {product_high_reg, product_low_reg});
      chk("done calc", 32'h0, done);
      @(posedge clk);
      #1;
      chk("done end", 32'h1, done);
      chk("busy end", 32'h0, busy);
      chk("prod low", exp[15:0], product_low_reg);
      chk("prod high", exp[31:16], product_high_reg);
      @(posedge clk);
      #1;
      chk("done pulse", 32'h0, done);
   endtask

   task automatic rd(input logic hi, input umu_opnd_t exp);
      @(posedge clk);
      rd_en       <= 1'b1;
      rd_sel_high <= hi;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      chk(hi ? "read high" : "read low", exp, rd_data);
   endtask

   // -------------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------------
   task automatic s_reset();
      chk("mode rst", 32'h0, muldiv_mode_control);
      chk("prod rst", 32'h0, {product_high_reg, product_low_reg});
      chk("busy rst", 32'h0, busy);
      chk("done rst", 32'h0, done);
   endtask

   // multiplicand first, then multiplier: 2 x 3
   task automatic s_low_first();
      wr(1'b1, 8'h00, 1'b0, 16'h0000, 1'b0, 16'h0000);
      wr(1'b0, 8'h00, 1'b1, 16'h0002, 1'b0, 16'h0000);
      wr(1'b0, 8'h00, 1'b0, 16'h0000, 1'b1, 16'h0003);
      run_op(16'h0002, 16'h0003, 32'h0000_0000);
   endtask

   // multiplier first; nothing may start on one operand alone
   task automatic s_high_first();
      wr(1'b1, 8'h00, 1'b0, 16'h0000, 1'b0, 16'h0000);
      wr(1'b0, 8'h00, 1'b0, 16'h0000, 1'b1, 16'hffff);
      repeat (3) @(posedge clk);
      #1;
      chk("no start", 32'h0, busy | done);
      chk("held", 32'h6, {product_high_reg, product_low_reg});
      wr(1'b0, 8'h00, 1'b1, 16'hffff, 1'b0, 16'h0000);
      run_op(16'hffff, 16'hffff, 32'h0000_0006);
   endtask

   // repeat with the multiplier only, mode and multiplicand kept
   task automatic s_repeat();
      wr(1'b0, 8'h00, 1'b0, 16'h0000, 1'b1, 16'h0003);
      run_op(16'hffff, 16'h0003, 32'hfffe_0001);
      chk("mode kept", 32'h0, muldiv_mode_control);
      chk("low kept", 32'hffff, operand_low_reg);
   endtask

   // both read orders, the product left untouched by reads
   task automatic s_reads();
      rd(1'b1, 16'h0002);
      rd(1'b0, 16'hfffd);
      rd(1'b0, 16'hfffd);
      rd(1'b1, 16'h0002);
      chk("after reads", 32'h0002_fffd,
          {product_high_reg, product_low_reg});
   endtask

   // another mode stores operands but starts nothing
   task automatic s_other_mode();
      wr(1'b1, 8'h01, 1'b0, 16'h0000, 1'b0, 16'h0000);
      wr(1'b0, 8'h00, 1'b1, 16'h0004, 1'b0, 16'h0000);
      wr(1'b0, 8'h00, 1'b0, 16'h0000, 1'b1, 16'h0005);
      repeat (4) @(posedge clk);
      #1;
      chk("no op", 32'h0, busy | done);
      chk("prod same", 32'h0002_fffd,
          {product_high_reg, product_low_reg});
      chk("opnds", 32'h0005_0004,
          {operand_high_reg, operand_low_reg});
      wr(1'b1, 8'h00, 1'b0, 16'h0000, 1'b0, 16'h0000);
      wr(1'b0, 8'h00, 1'b1, 16'h0004, 1'b0, 16'h0000);
      wr(1'b0, 8'h00, 1'b0, 16'h0000, 1'b1, 16'h0005);
      run_op(16'h0004, 16'h0005, 32'h0002_fffd);
   endtask

   // a low enable ignores strobes; nothing is stored or started
   task automatic s_freeze();
      @(posedge clk);
      ce <= 1'b0;
      wr(1'b0, 8'h00, 1'b0, 16'h0000, 1'b1, 16'h0007);
      repeat (2) @(posedge clk);
      #1;
      chk("frozen opnd", 32'h0005, operand_high_reg);
      chk("frozen op", 32'h0, busy | done);
      chk("frozen prod", 32'h0000_0014,
          {product_high_reg, product_low_reg});
      @(posedge clk);
      ce <= 1'b1;
   endtask

   // -------------------------------------------------------------------
   // closing report and main sequence
   // -------------------------------------------------------------------
   task automatic complete_run();
      if (mismatches == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      reset = 1'b1;
      ce = 1'b1;
      mode_wr = 1'b0;
      mode_wdata = 8'h00;
      opl_wr = 1'b0;
      opl_wdata = 16'h0000;
      oph_wr = 1'b0;
      oph_wdata = 16'h0000;
      rd_en = 1'b0;
      rd_sel_high = 1'b0;
      mismatches = 0;
      comparisons = 0;
      cycles = 0;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      #1;
      s_reset();
      s_low_first();
      s_high_first();
      s_repeat();
      s_reads();
      s_other_mode();
      s_freeze();
      complete_run();
   end
endmodule
